// [include/dpm_pkg.sv]
// dpm_pkg: constants, register map and pin bundle for the dual-port ram host
// assumes a 100 MHz REF_CLK; all pin timing is rounded up to whole cycles
package dpm_pkg;

   localparam int CLK_NS      = 10;   // REF_CLK period
   // pin timing in ns; plain defaults, set to the grade of the fitted part
   localparam int ACCESS_NS   = 30;   // enable_access_time / output_access_time
   localparam int FLOW_NS     = 30;   // flow_through_delay
   localparam int FLAG_NS     = 20;   // flag_after_enable_delay
   localparam int WRPULSE_NS  = 20;   // write strobe width
   localparam int TURN_NS     = 20;   // token_turnaround_time
   localparam int SYNC_CYC    = 2;    // pin synchroniser depth

   // least time to cycles: round up, never below one
   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int READ_CYC    = ceil_cyc((ACCESS_NS > FLOW_NS) ? ACCESS_NS : FLOW_NS);
   localparam int ARB_CYC     = ceil_cyc(FLAG_NS);
   localparam int WRPULSE_CYC = ceil_cyc(WRPULSE_NS);
   localparam int TURN_CYC    = ceil_cyc(TURN_NS);

   // own register map, byte addresses on APB
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_ADDR   = 12'h004;
   localparam logic [11:0] REG_WDATA  = 12'h008;
   localparam logic [11:0] REG_RDATA  = 12'h00c;
   localparam logic [11:0] REG_STATUS = 12'h010;

   // control fields
   localparam int CTRL_START  = 0;
   localparam int CTRL_OP_LSB = 1;
   localparam int CTRL_UB     = 3;
   localparam int CTRL_LB     = 4;
   // status fields
   localparam int ST_ACTIVE   = 0;
   localparam int ST_DONE     = 1;
   localparam int ST_CONT     = 2;
   localparam int ST_IRQ      = 3;
   localparam int ST_FLAG     = 4;

   typedef enum logic [1:0] {OP_MEM_RD, OP_MEM_WR, OP_SEM_RD, OP_SEM_WR} dpm_op_e;

   // active-low control pins of one port
   typedef struct packed {
      logic ce_n;
      logic rw_n;
      logic oe_n;
      logic ub_n;
      logic lb_n;
      logic sem_n;
   } dpm_pins_s;

   localparam dpm_pins_s PINS_IDLE = dpm_pins_s'(6'h3f);

endpackage

// [design/dpm_sync.sv]
// dpm_sync: two-flop synchroniser for pins that change off REF_CLK
// assumes idle-high inputs, so both stages reset to ones
`timescale 1ns/1ns
module dpm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,     // sampling clock
   input  wire logic         rst_n,   // synchronous reset, active low
   input  wire logic         ce,      // clock enable, freezes both stages
   input  wire logic [W-1:0] d,       // asynchronous inputs
   output logic      [W-1:0] q        // synchronised outputs
);
   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta <= '1;
         q    <= '1;
      end else if (ce) begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// [design/dpm_host.sv]
// dpm_host: APB-programmed controller driving one port of an asynchronous
// dual-port ram with mailbox, contention flag and token latches
// assumes the port pins are registered here and sampled back through dpm_sync
`timescale 1ns/1ns

// Functional notes
// - a write ends on the rising edge of write_not_read while enable stays low
// - opposite-port data is valid only after the flow-through delay
// - reads assert chip enable and output enable, data taken after access time
// - token access uses token_select instead of chip enable, output enable for reads
// - writes start only after contention_flag has settled; token writes here go to the strobe without that wait
// - chip enable stays high during token access, never with a byte select low
// - after a token write, hold token_select high for the turnaround time
module dpm_host import dpm_pkg::*; #(
   parameter int AW = 13,
   parameter int DW = 16
) (
   input  wire logic          REF_CLK,              // 100 MHz clock
   input  wire logic          RST_N,                // synchronous reset, active low
   input  wire logic          CKE,                  // clock enable, low freezes state
   input  wire logic          PSEL,                 // apb select
   input  wire logic          PENABLE,              // apb access phase
   input  wire logic          PWRITE,               // apb direction
   input  wire logic [11:0]   PADDR,                // apb byte address
   input  wire logic [31:0]   PWDATA,               // apb write data
   output logic      [31:0]   PRDATA,               // apb read data
   output logic               PREADY,               // apb ready
   output logic               PSLVERR,              // apb error, unmapped address
   output logic      [AW-1:0] MEM_ADDR,             // port address
   output logic               CHIP_ENABLE_N,        // memory select
   output logic               WRITE_NOT_READ,       // high read, low write
   output logic               OUTPUT_ENABLE_N,      // read output enable
   output logic               UPPER_BYTE_SELECT_N,  // upper lane select
   output logic               LOWER_BYTE_SELECT_N,  // lower lane select
   output logic               TOKEN_SELECT_N,       // token latch select
   output logic      [DW-1:0] DQ_O,                 // data driven to the port
   output logic               DQ_OE,                // high while driving data
   input  wire logic [DW-1:0] DQ_I,                 // data seen on the port
   input  wire logic          MAILBOX_IRQ_N,        // port mailbox_irq
   input  wire logic          CONTENTION_FLAG_N     // port contention_flag
);
   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_ENABLE, S_STROBE, S_RELEASE,
                             S_GAP} dpm_state_e;

   localparam int          HALF      = DW / 2;
   // one spare cycle each: a flag or data edge landing on a clock edge has no setup margin
   localparam logic [7:0]  ARB_LAST  = 8'(ARB_CYC + SYNC_CYC);
   localparam logic [7:0]  RD_LAST   = 8'(READ_CYC + SYNC_CYC);
   localparam logic [7:0]  WR_LAST   = 8'(WRPULSE_CYC - 1);
   localparam logic [7:0]  TURN_LAST = 8'(TURN_CYC - 1);

   if (DW < 9 || DW > 32 || AW < 3 || AW > 31 || READ_CYC + SYNC_CYC > 255) begin : g_bad
      $error("dpm_host: unsupported width or timing");
   end

   dpm_state_e    state;
   dpm_pins_s     p;
   dpm_op_e       op_r;
   logic [7:0]    cnt;
   logic [AW-1:0] addr_r;
   logic [DW-1:0] wdata_r;
   logic [DW-1:0] rdata_r;
   logic          ub_en;
   logic          lb_en;
   logic          done;
   logic          cont;
   logic [DW+1:0] sync_q;
   logic          busy_s;
   logic          irq_s;
   logic [DW-1:0] dq_s;
   logic          wr_acc;
   logic          start;
   logic          arb_end;
   logic          gap_end;
   logic [31:0]   status_w;

   function automatic logic op_is_sem(input dpm_op_e op);
      return (op == OP_SEM_RD) || (op == OP_SEM_WR);
   endfunction

   function automatic logic op_is_wr(input dpm_op_e op);
      return (op == OP_MEM_WR) || (op == OP_SEM_WR);
   endfunction

   // contention flag, mailbox irq and read data all come off the pins
   dpm_sync #(.W(DW + 2)) u_sync (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .ce    (CKE),
      .d     ({CONTENTION_FLAG_N, MAILBOX_IRQ_N, DQ_I}),
      .q     (sync_q)
   );
   assign busy_s = ~sync_q[DW+1];
   assign irq_s  = ~sync_q[DW];
   assign dq_s   = sync_q[DW-1:0];

   // pin outputs straight from the pin register, MEM_ADDR straight from addr_r
   assign CHIP_ENABLE_N       = p.ce_n;
   assign WRITE_NOT_READ      = p.rw_n;
   assign OUTPUT_ENABLE_N     = p.oe_n;
   assign UPPER_BYTE_SELECT_N = p.ub_n;
   assign LOWER_BYTE_SELECT_N = p.lb_n;
   assign TOKEN_SELECT_N      = p.sem_n;
   assign MEM_ADDR            = addr_r;

   // zero-wait apb slave; unmapped addresses answer with an error
   assign PREADY  = 1'b1;
   assign wr_acc  = PSEL && PENABLE && PWRITE;
   assign PSLVERR = PSEL && PENABLE && !(PADDR inside {REG_CTRL, REG_ADDR, REG_WDATA,
                                                      REG_RDATA, REG_STATUS});
   assign start   = wr_acc && (PADDR == REG_CTRL) && PWDATA[CTRL_START] && (state == S_IDLE);
   assign arb_end = (state == S_ENABLE) && !op_is_sem(op_r) && (cnt == ARB_LAST);
   assign gap_end = (state == S_GAP) && ((op_r != OP_SEM_WR) || (cnt == TURN_LAST));

   // status word, reserved bits read zero
   always_comb begin
      status_w            = '0;
      status_w[ST_ACTIVE] = (state != S_IDLE);
      status_w[ST_DONE]   = done;
      status_w[ST_CONT]   = cont;
      status_w[ST_IRQ]    = irq_s;
      status_w[ST_FLAG]   = busy_s;
   end

   // read data registered in the setup phase, valid through the access phase
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         PRDATA <= '0;
      end else if (CKE && PSEL && !PENABLE) begin
         unique case (PADDR)
            REG_CTRL:   PRDATA <= 32'({lb_en, ub_en, op_r, 1'b0});
            REG_ADDR:   PRDATA <= 32'(addr_r);
            REG_WDATA:  PRDATA <= 32'(wdata_r);
            REG_RDATA:  PRDATA <= 32'(rdata_r);
            REG_STATUS: PRDATA <= status_w;
            default:    PRDATA <= '0;
         endcase
      end
   end

   // command registers; ignored while a pin cycle runs so pins stay stable
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         op_r    <= OP_MEM_RD;
         ub_en   <= 1'b1;
         lb_en   <= 1'b1;
         addr_r  <= '0;
         wdata_r <= '0;
      end else if (CKE && wr_acc && state == S_IDLE) begin
         if (PADDR == REG_CTRL) begin
            op_r  <= dpm_op_e'(PWDATA[CTRL_OP_LSB +: 2]);
            ub_en <= PWDATA[CTRL_UB];
            lb_en <= PWDATA[CTRL_LB];
         end
         if (PADDR == REG_ADDR)
            addr_r <= PWDATA[AW-1:0];
         if (PADDR == REG_WDATA)
            wdata_r <= PWDATA[DW-1:0];
      end
   end

   // pin sequencer: setup, enable/arbitrate, strobe, release, turnaround
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         state   <= S_IDLE;
         cnt     <= '0;
         p       <= PINS_IDLE;
         DQ_O    <= '0;
         DQ_OE   <= 1'b0;
         rdata_r <= '0;
      end else if (CKE) begin
         unique case (state)
            S_IDLE: begin
               if (start)
                  state <= S_SETUP;
            end
            S_SETUP: begin
               state <= S_ENABLE;
               cnt   <= '0;
               DQ_O  <= wdata_r;
               DQ_OE <= op_is_wr(op_r);
               if (op_is_sem(op_r)) begin
                  p.sem_n <= 1'b0;
               end else begin
                  p.ce_n <= 1'b0;
                  p.ub_n <= !ub_en;
                  p.lb_n <= !lb_en;
               end
            end
            S_ENABLE: begin
               cnt <= cnt + 8'd1;
               // memory cycles wait for the flag to settle and pass the synchroniser
               if (op_is_sem(op_r) || cnt == ARB_LAST) begin
                  cnt <= '0;
                  if (arb_end && busy_s && op_is_wr(op_r)) begin
                     state <= S_RELEASE;
                  end else begin
                     state <= S_STROBE;
                     if (op_is_wr(op_r))
                        p.rw_n <= 1'b0;
                     else
                        p.oe_n <= 1'b0;
                  end
               end
            end
            S_STROBE: begin
               cnt <= cnt + 8'd1;
               if (op_is_wr(op_r) && cnt == WR_LAST) begin
                  p.rw_n <= 1'b1;
                  state  <= S_RELEASE;
               end else if (!op_is_wr(op_r) && cnt == RD_LAST) begin
                  // unselected lanes float, so they are masked to zero
                  rdata_r <= op_is_sem(op_r) ? dq_s :
                             dq_s & {{(DW - HALF){ub_en}}, {HALF{lb_en}}};
                  p.oe_n  <= 1'b1;
                  state   <= S_RELEASE;
               end
            end
            S_RELEASE: begin
               // data held one cycle past the write strobe for hold time
               p     <= PINS_IDLE;
               DQ_OE <= 1'b0;
               cnt   <= '0;
               state <= S_GAP;
            end
            S_GAP: begin
               cnt <= cnt + 8'd1;
               if (gap_end)
                  state <= S_IDLE;
            end
         endcase
      end
   end

   // done flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge REF_CLK) begin
      if (!RST_N)
         done <= 1'b0;
      else if (CKE && gap_end)
         done <= 1'b1;
      else if (CKE && wr_acc && PADDR == REG_STATUS && PWDATA[ST_DONE])
         done <= 1'b0;
   end

   // contention seen at the end of arbitration, sticky until cleared
   always_ff @(posedge REF_CLK) begin
      if (!RST_N)
         cont <= 1'b0;
      else if (CKE && arb_end && busy_s)
         cont <= 1'b1;
      else if (CKE && wr_acc && PADDR == REG_STATUS && PWDATA[ST_CONT])
         cont <= 1'b0;
   end

   // helper run counters for the checks below
   logic [7:0] oe_run;
   logic [7:0] ce_run;
   logic       sem_wr;
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         oe_run <= '0;
         ce_run <= '0;
         sem_wr <= 1'b0;
      end else if (CKE) begin
         oe_run <= p.oe_n ? 8'd0 : ((oe_run == 8'hff) ? oe_run : oe_run + 8'd1);
         ce_run <= p.ce_n ? 8'd0 : ((ce_run == 8'hff) ? ce_run : ce_run + 8'd1);
         // kept from the write strobe until the next token access opens
         if (!p.sem_n && !p.rw_n)
            sem_wr <= 1'b1;
         else if (!p.sem_n && state == S_ENABLE)
            sem_wr <= 1'b0;
      end
   end

   a_ce_sem_excl: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !(!p.ce_n && !p.sem_n)) else $error("chip enable and token select both low");

   a_sem_lanes_shut: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !p.sem_n |-> (p.ub_n && p.lb_n)) else $error("byte lane open during token access");

   a_write_end_rw: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      $rose(p.rw_n) |-> (!p.ce_n || !p.sem_n)) else $error("write not ended by write line");

   a_read_enables: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !p.oe_n |-> (p.rw_n && (p.ce_n != p.sem_n))) else $error("read without one select");

   a_read_wait: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      $rose(p.oe_n) |-> (oe_run > RD_LAST)) else $error("output enable released too early");

   a_write_settled: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ($fell(p.rw_n) && !p.ce_n) |-> (!$past(busy_s) && ce_run > ARB_LAST))
      else $error("write started before flag settled");

   a_token_gap: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ($rose(p.sem_n) && sem_wr) |-> p.sem_n [*2]) else $error("token turnaround too short");

   a_no_drive_read: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      DQ_OE |-> (p.oe_n && !p.rw_n || p.oe_n && state != S_STROBE))
      else $error("data driven while port reads");

   a_lane_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !p.ce_n |-> ({p.ub_n, p.lb_n} == ~{ub_en, lb_en})) else $error("wrong byte lanes");

   a_read_capture: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CKE && state == S_STROBE && op_r == OP_SEM_RD && cnt == RD_LAST) |=> rdata_r == $past(dq_s))
      else $error("token read value not latched");
endmodule

// [dv/dpm_ram_model.sv]
// dpm_ram_model: behavioural dual-port ram as seen from its left port
// assumes the bench plays the right port through the r_* inputs
`timescale 1ns/1ns
module dpm_ram_model import dpm_pkg::*; #(
   parameter int AW = 13
) (
   input  wire dpm_pins_s     pins,    // left port controls
   input  wire logic [AW-1:0] addr,    // left address
   input  wire logic [15:0]   dq,      // resolved data wire
   output logic      [15:0]   dq_drv,  // model drive onto the wire
   output logic               irq_n,   // left mailbox_irq
   output logic               busy_n,  // left contention_flag
   input  wire logic          slow,    // full access time instead of a fast answer
   input  wire logic          r_ce,    // right port selects r_addr
   input  wire logic [AW-1:0] r_addr,  // right address
   input  wire logic          r_wr,    // right memory write strobe
   input  wire logic          r_sem,   // right token write strobe
   input  wire logic [15:0]   r_data   // right write data, bit 0 for tokens
);
   localparam logic [AW-1:0] MBOX_L = {{(AW-1){1'b1}}, 1'b0};
   logic [15:0] mem [2**AW];
   logic [7:0]  own [2];
   logic [7:0]  req [2];
   logic [15:0] lat;
   logic [15:0] ln;
   logic [15:0] last;
   logic        en;
   logic        wsem;
   wire         rd_on = pins.rw_n && !pins.oe_n && (!pins.sem_n ||
                        (!pins.ce_n && !(pins.ub_n && pins.lb_n)));
   wire         wr_on = !pins.rw_n && (!pins.sem_n || !pins.ce_n);
   wire         match = r_ce && !pins.ce_n && addr == r_addr;

   // power-up state: tokens free, no interrupt
   initial begin
      own = '{8'h0, 8'h0};
      req = '{8'h0, 8'h0};
      irq_n = 1'b1;
      busy_n = 1'b1;
      en = 1'b0;
      last = 16'h0;
   end

   // token write in zero time, so two racing ports get one winner
   task automatic sem_wr(input int p, input logic [2:0] i, input logic b);
      if (!b && !own[0][i] && !own[1][i])
         own[p][i] = 1'b1;
      else if (!b && !own[p][i])
         req[p][i] = 1'b1;
      else if (b) begin
         req[p][i] = 1'b0;
         if (own[p][i]) begin
            own[p][i] = 1'b0;
            own[1-p][i] = req[1-p][i];
            req[1-p][i] = 1'b0;
         end
      end
   endtask

   // left writes land on the closing edge of strobe or select
   always @(posedge wr_on)
      wsem = !pins.sem_n;
   always @(negedge wr_on) begin
      if (wsem === 1'b1)
         sem_wr(1, addr[2:0], dq[0]);
      else if (busy_n && !pins.ub_n)
         mem[addr][15:8] = dq[15:8];
      if (wsem === 1'b0 && busy_n && !pins.lb_n)
         mem[addr][7:0] = dq[7:0];
   end

   // right port writes at once; a left read sees it after its own wait
   always @(posedge r_wr) begin
      mem[r_addr] = r_data;
      if (r_addr == MBOX_L)
         irq_n = 1'b0;
   end
   always @(posedge r_sem)
      sem_wr(0, r_addr[2:0], r_data[0]);

   // left read: value latched after the access time, held until release
   always @(rd_on) begin
      en = 1'b0;
      if (rd_on) begin
         #(slow ? ACCESS_NS : 5);
         lat = pins.sem_n ? mem[addr] : {16{!own[1][addr[2:0]]}};
         ln = pins.sem_n ? {{8{!pins.ub_n}}, {8{!pins.lb_n}}} : 16'hffff;
         if (pins.sem_n && addr == MBOX_L && busy_n)
            irq_n = 1'b1;
         en = rd_on;
      end
   end

   // released lanes show the inverse of the last value, never a held copy
   always @(negedge en)
      last = lat;
   assign dq_drv = en ? (lat & ln) | (~last & ~ln) : ~last;

   // left always loses a match against the right port, after the flag delay
   always @(match)
      busy_n <= #(FLAG_NS) !match;
endmodule

// [dv/dual_port_ram_arbiter_mailbox_tb.sv]
// dual_port_ram_arbiter_mailbox_tb: apb-driven bench for the port host
// assumes dpm_ram_model on the port; the bench plays the right port
`timescale 1ns/1ns
module dual_port_ram_arbiter_mailbox_tb import dpm_pkg::*; ();
   localparam int AW = 13;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [11:0]   paddr = 12'h0;
   logic [31:0]   pwdata = 32'h0;
   logic [31:0]   prdata;
   logic [31:0]   rdq;
   logic          pready;
   logic          pslverr;
   logic [AW-1:0] maddr;
   wire dpm_pins_s pins;
   logic [15:0]   dq_o;
   logic          dq_oe;
   logic [15:0]   dq_drv;
   logic          irq_n;
   logic          busy_n;
   logic          slow = 1'b1;
   logic          cke = 1'b1;
   logic          r_ce = 1'b0;
   logic          r_wr = 1'b0;
   logic          r_sem = 1'b0;
   logic [AW-1:0] r_addr = '0;
   logic [15:0]   r_data = 16'h0;
   logic [32:0]   exp_q [$];
   logic [32:0]   msk_q [$];
   int            n_mismatch = 0;
   int            n_checks = 0;
   wire  [15:0]   dq = dq_oe ? dq_o : dq_drv; // resolved data wire

   always #(CLK_NS / 2) clk = ~clk;

   dpm_host #(.AW(AW), .DW(16)) i_dut (
      .REF_CLK(clk), .RST_N(rst_n), .CKE(cke), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .MEM_ADDR(maddr), .CHIP_ENABLE_N(pins.ce_n),
      .WRITE_NOT_READ(pins.rw_n), .OUTPUT_ENABLE_N(pins.oe_n),
      .UPPER_BYTE_SELECT_N(pins.ub_n), .LOWER_BYTE_SELECT_N(pins.lb_n),
      .TOKEN_SELECT_N(pins.sem_n), .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq),
      .MAILBOX_IRQ_N(irq_n), .CONTENTION_FLAG_N(busy_n));

   dpm_ram_model #(.AW(AW)) i_ram (
      .pins(pins), .addr(maddr), .dq(dq), .dq_drv(dq_drv), .irq_n(irq_n),
      .busy_n(busy_n), .slow(slow), .r_ce(r_ce), .r_addr(r_addr), .r_wr(r_wr),
      .r_sem(r_sem), .r_data(r_data));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] s);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rdq = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // a read notes its expectation first; mask zero means no check
   task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask

   // program, start, poll done under a bound, check and clear status
   task automatic op(input dpm_op_e o, input logic [AW-1:0] a, input logic [15:0] d,
                     input logic [1:0] lb_ub, input logic cont);
      int n;
      n = 0;
      slow <= 1'($urandom_range(1));
      apb(1'b1, REG_ADDR, 32'(a));
      apb(1'b1, REG_WDATA, {16'h0, d});
      apb(1'b1, REG_CTRL, {27'h0, lb_ub, o, 1'b1});
      // freeze the started cycle a while; the results must not change
      cke <= 1'b0;
      repeat (1 + $urandom_range(2)) @(posedge clk);
      cke <= 1'b1;
      do begin
         rd(REG_STATUS, '0, '0);
         n++;
      end while (rdq[ST_DONE] !== 1'b1 && n < 100);
      rd(REG_STATUS, {30'h0, cont, 2'b10}, 33'h7);
      apb(1'b1, REG_STATUS, 32'h6);
   endtask

   // right port strobe: memory write or token write
   task automatic rport(input logic token_select, input logic [AW-1:0] a, input logic [15:0] d);
      r_addr <= a;
      r_data <= d;
      r_sem <= token_select;
      r_wr <= !token_select;
      @(posedge clk);
      r_sem <= 1'b0;
      r_wr <= 1'b0;
      @(posedge clk);
   endtask

   // takes the oldest note whenever a read completes
   always @(posedge clk)
      if (psel && penable && pready === 1'b1 && !pwrite && msk_q.size() > 0) begin
         if (msk_q[0] !== '0)
            cmp($sformatf("reg %h", paddr), exp_q[0], {pslverr, prdata} & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end

   // token select and chip enable are never low together
   always @(posedge clk)
      if (rst_n && pins.sem_n === 1'b0)
         cmp("enable in token access", 33'h1, 33'(pins.ce_n));

   initial begin
      #(20000 * CLK_NS);
      n_mismatch++;
      finish_test();
   end

   initial begin
      logic [15:0]   d;
      logic [15:0]   d2;
      logic [AW-1:0] a;
      int            seed;
      seed = $urandom(32484);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(REG_CTRL, 33'h18, 33'h1f);
      rd(REG_STATUS, 33'h0, 33'h1f);
      rd(12'h014, 33'h1_0000_0000, 33'h1_0000_0000);
      repeat (2) begin
         a = AW'($urandom_range(2 ** AW - 3));
         d = 16'($urandom);
         d2 = 16'($urandom);
         op(OP_MEM_WR, a, d, 2'b11, 1'b0);
         op(OP_MEM_WR, a, d2, 2'b01, 1'b0);
         op(OP_MEM_RD, a, 16'h0, 2'b10, 1'b0);
         rd(REG_RDATA, {25'h0, d[7:0]}, 33'h1ffff);
         op(OP_MEM_RD, a, 16'h0, 2'b11, 1'b0);
         rd(REG_RDATA, {17'h0, d2[15:8], d[7:0]}, 33'h1ffff);
         rport(1'b0, a, d2);
         r_ce <= 1'b1;
         op(OP_MEM_WR, a, d, 2'b11, 1'b1);
         r_ce <= 1'b0;
         op(OP_MEM_RD, a, 16'h0, 2'b11, 1'b0);
         rd(REG_RDATA, {17'h0, d2}, 33'h1ffff);
      end
      rport(1'b0, 13'h1ffe, d);
      repeat (SYNC_CYC + 1) @(posedge clk);
      rd(REG_STATUS, 33'h8, 33'h8);
      op(OP_MEM_RD, 13'h1fff, 16'h0, 2'b11, 1'b0);
      rd(REG_STATUS, 33'h8, 33'h8);
      r_ce <= 1'b1;
      op(OP_MEM_RD, 13'h1ffe, 16'h0, 2'b11, 1'b1);
      r_ce <= 1'b0;
      rd(REG_STATUS, 33'h8, 33'h8);
      op(OP_MEM_RD, 13'h1ffe, 16'h0, 2'b11, 1'b0);
      rd(REG_RDATA, {17'h0, d}, 33'h1ffff);
      rd(REG_STATUS, 33'h0, 33'h8);
      for (int i = 0; i < 8; i++) begin
         op(OP_SEM_WR, AW'(i + 8 * $urandom_range(1000)), 16'h0, 2'b00, 1'b0);
         op(OP_SEM_RD, AW'(i), 16'h0, 2'b00, 1'b0);
         rd(REG_RDATA, 33'h0, 33'h1ffff);
      end
      a = AW'($urandom_range(7));
      rport(1'b1, a, 16'h0);
      op(OP_SEM_WR, a, 16'h1, 2'b00, 1'b0);
      op(OP_SEM_RD, a, 16'h0, 2'b00, 1'b0);
      rd(REG_RDATA, 33'hffff, 33'h1ffff);
      op(OP_SEM_WR, a, 16'h0, 2'b00, 1'b0);
      rport(1'b1, a, 16'h1);
      op(OP_SEM_RD, a, 16'h0, 2'b00, 1'b0);
      rd(REG_RDATA, 33'h0, 33'h1ffff);
      repeat (2) @(posedge clk);
      finish_test();
   end
endmodule
